// ==== hdl/seq_table_pkg.sv ====
// Constants for the sequence table and buffer access register bank
package seq_table_pkg;
   // Printed register offsets are indices; byte address is four times
   localparam logic [7:0] IDX_SLAVE_TABLE = 8'he3;
   localparam logic [7:0] IDX_TXN_CONFIG  = 8'he4;
   localparam logic [7:0] IDX_DATA_PORT   = 8'he5;
   localparam logic [7:0] IDX_TXN_SELECT  = 8'he6;
   localparam logic [7:0] IDX_BYTE_OFFSET = 8'he7;
   localparam logic [7:0] IDX_CONTROL     = 8'hf0;
   localparam logic [7:0] IDX_CTRL_STATUS = 8'hf1;
   // Control register fields
   localparam int CTRL_REWIND_BIT = 0;
   localparam int CTRL_START_BIT  = 1;
   // Controller status fields
   localparam int STAT_BUF_ERR_BIT = 0;
   localparam int STAT_BUSY_BIT    = 1;
   // Table and buffer geometry
   localparam int SLAVE_ENTRIES = 64;
   localparam int CFG_ENTRIES   = 65;
   localparam int BUF_DEPTH     = 4352;
   localparam logic [6:0] MAX_TXN_COUNT = 7'h40;
   localparam logic [5:0] SEL_FIELD_MAX = 6'h3f;
   // Reset values and data returned from beyond the buffer
   localparam logic [5:0] TXN_SELECT_RST  = 6'h00;
   localparam logic [7:0] BYTE_OFFSET_RST = 8'h00;
   localparam logic [7:0] INVALID_DATA    = 8'h00;
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ==== hdl/seq_table_bank.sv ====
// Slave table, transaction config table and buffer data port, AXI4-Lite
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module seq_table_bank
   import seq_table_pkg::*;
(
   input  wire logic        SYS_CLK,
   input  wire logic        RESETN,
   input  wire logic [11:0] S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [11:0] S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   input  wire logic        SEQ_BUSY,
   input  wire logic        SEQ_DONE,
   output logic             SEQ_START,
   input  wire logic [5:0]  SEQ_TXN_IDX,
   output logic [6:0]       SEQ_SLAVE_ADDR,
   output logic [7:0]       SEQ_TXN_LEN,
   output logic             SEQ_TXN_VALID,
   output logic             SEQ_TXN_EMPTY,
   input  wire logic [12:0] SEQ_BUF_ADDR,
   output logic [7:0]       SEQ_BUF_DATA
);

   ////////////////////////////////////////////////////////////////////////
   logic        rst_meta_r;
   logic        rst_n;
   logic        aw_full_r;
   logic        w_full_r;
   logic [7:0]  aw_idx_r;
   logic [7:0]  wdat_r;
   logic        wstrb0_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        rvalid_r;
   logic [1:0]  rresp_r;
   logic [7:0]  rdata_r;
   logic        wr_fire;
   logic        wr_en;
   logic        rd_fire;
   logic [7:0]  rd_idx;
   logic [7:0]  rd_val;
   logic [7:0]  slave_tab [SLAVE_ENTRIES];
   logic [7:0]  len_tab [SLAVE_ENTRIES];
   logic [6:0]  txn_count_r;
   logic [5:0]  sla_ptr_r;
   logic [6:0]  cfg_ptr_r;
   logic [5:0]  sel_r;
   logic [7:0]  ofs_r;
   logic [13:0] ptr_r;
   logic [7:0]  buf_mem [BUF_DEPTH];
   logic        start_r;
   logic        seq_start_r;
   logic        buf_err_r;
   logic        idle;
   logic        ptr_oob;
   logic        rewind;
   logic        wr_data;
   logic        rd_data;
   logic        wr_sla;
   logic        rd_sla;
   logic        wr_cfg;
   logic        rd_cfg;
   logic        wr_sel;
   logic        wr_ofs;
   logic [13:0] sel_ptr;
   logic [13:0] ofs_ptr;
   logic [13:0] rew_ptr;

   function automatic logic mapped(input logic [7:0] idx);
      mapped = (idx >= IDX_SLAVE_TABLE && idx <= IDX_BYTE_OFFSET) ||
               idx == IDX_CONTROL || idx == IDX_CTRL_STATUS;
   endfunction

   // Sum of the lengths of all transactions before sel
   function automatic logic [13:0] txn_base(input logic [5:0] sel);
      logic [13:0] acc;
      acc = 14'h0000;
      for (int i = 0; i < SLAVE_ENTRIES; i++) begin
         if (i < int'(sel)) begin
            acc = acc + {6'h00, len_tab[i]};
         end
      end
      txn_base = acc;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Reset release
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   always_comb begin
      wr_fire = aw_full_r & w_full_r & ~bvalid_r;
      wr_en   = wr_fire & wstrb0_r;
      S_AXI_AWREADY = ~aw_full_r;
      S_AXI_WREADY  = ~w_full_r;
      // Writes win the cycle so a port never moves twice at once
      S_AXI_ARREADY = ~rvalid_r & ~wr_fire;
      rd_fire = S_AXI_ARVALID & S_AXI_ARREADY;
      rd_idx  = S_AXI_ARADDR[9:2];
      idle    = ~start_r & ~SEQ_BUSY;
      ptr_oob = ptr_r >= 14'(BUF_DEPTH);
      wr_data = wr_en & aw_idx_r == IDX_DATA_PORT & idle;
      rd_data = rd_fire & rd_idx == IDX_DATA_PORT;
      wr_sla  = wr_en & aw_idx_r == IDX_SLAVE_TABLE;
      rd_sla  = rd_fire & rd_idx == IDX_SLAVE_TABLE;
      wr_cfg  = wr_en & aw_idx_r == IDX_TXN_CONFIG;
      rd_cfg  = rd_fire & rd_idx == IDX_TXN_CONFIG;
      wr_sel  = wr_en & aw_idx_r == IDX_TXN_SELECT;
      wr_ofs  = wr_en & aw_idx_r == IDX_BYTE_OFFSET;
      rewind  = wr_en & aw_idx_r == IDX_CONTROL & wdat_r[CTRL_REWIND_BIT];
      sel_ptr = txn_base(wdat_r[5:0]);
      ofs_ptr = txn_base(sel_r) + {6'h00, wdat_r};
      rew_ptr = txn_base(sel_r) + {6'h00, ofs_r};
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         aw_full_r <= 1'b0;
         aw_idx_r  <= 8'h00;
      end else if (!aw_full_r && S_AXI_AWVALID) begin
         aw_full_r <= 1'b1;
         aw_idx_r  <= S_AXI_AWADDR[9:2];
      end else if (wr_fire) begin
         aw_full_r <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         w_full_r <= 1'b0;
         wdat_r   <= 8'h00;
         wstrb0_r <= 1'b0;
      end else if (!w_full_r && S_AXI_WVALID) begin
         w_full_r <= 1'b1;
         wdat_r   <= S_AXI_WDATA[7:0];
         wstrb0_r <= S_AXI_WSTRB[0];
      end else if (wr_fire) begin
         w_full_r <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r  <= mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         bvalid_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data mux
   always_comb begin
      rd_val = 8'h00;
      unique case (rd_idx)
         IDX_SLAVE_TABLE: rd_val = slave_tab[sla_ptr_r];
         IDX_TXN_CONFIG:
            rd_val = (cfg_ptr_r == 7'h00) ? {1'b0, txn_count_r} :
                     len_tab[6'(cfg_ptr_r - 7'h01)];
         IDX_DATA_PORT:
            rd_val = ptr_oob ? INVALID_DATA :
                     buf_mem[ptr_r[12:0]];
         IDX_TXN_SELECT:  rd_val = {2'b00, sel_r};
         IDX_BYTE_OFFSET: rd_val = ofs_r;
         IDX_CONTROL:     rd_val = {6'h00, start_r, 1'b0};
         IDX_CTRL_STATUS: rd_val = {6'h00, ~idle, buf_err_r};
         default:         rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_r <= 1'b0;
         rresp_r  <= RESP_OKAY;
         rdata_r  <= 8'h00;
      end else if (rd_fire) begin
         rvalid_r <= 1'b1;
         rresp_r  <= mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
         rdata_r  <= rd_val;
      end else if (S_AXI_RREADY) begin
         rvalid_r <= 1'b0;
      end
   end

   assign S_AXI_BVALID = bvalid_r;
   assign S_AXI_BRESP  = bresp_r;
   assign S_AXI_RVALID = rvalid_r;
   assign S_AXI_RRESP  = rresp_r;
   assign S_AXI_RDATA  = {24'h000000, rdata_r};

   ////////////////////////////////////////////////////////////////////////
   // Slave address table
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         sla_ptr_r <= 6'h00;
      end else if (rewind) begin
         sla_ptr_r <= 6'h00;
      end else if (wr_sla || rd_sla) begin
         // Wraps after the 64th entry; pointer is never visible
         sla_ptr_r <= sla_ptr_r + 6'h01;
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < SLAVE_ENTRIES; i++) begin
            slave_tab[i] <= 8'h00;
         end
      end else if (wr_sla) begin
         slave_tab[sla_ptr_r] <= wdat_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transaction config table
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ptr_r <= 7'h00;
      end else if (rewind) begin
         cfg_ptr_r <= 7'h00;
      end else if ((wr_cfg || rd_cfg) && cfg_ptr_r < 7'(CFG_ENTRIES)) begin
         cfg_ptr_r <= cfg_ptr_r + 7'h01;
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         txn_count_r <= 7'h00;
         for (int i = 0; i < SLAVE_ENTRIES; i++) begin
            len_tab[i] <= 8'h00;
         end
      end else if (wr_cfg && cfg_ptr_r == 7'h00) begin
         // Counts above the maximum are held at the maximum
         txn_count_r <= (wdat_r > {1'b0, MAX_TXN_COUNT}) ?
                        MAX_TXN_COUNT : wdat_r[6:0];
      end else if (wr_cfg && cfg_ptr_r < 7'(CFG_ENTRIES)) begin
         len_tab[6'(cfg_ptr_r - 7'h01)] <= wdat_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Select, offset and data pointer
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         sel_r <= TXN_SELECT_RST;
      end else if (wr_sel) begin
         sel_r <= wdat_r[5:0] & SEL_FIELD_MAX;
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ofs_r <= BYTE_OFFSET_RST;
      end else if (wr_sel) begin
         ofs_r <= BYTE_OFFSET_RST;
      end else if (wr_ofs) begin
         ofs_r <= wdat_r;
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ptr_r <= 14'h0000;
      end else if (wr_sel) begin
         ptr_r <= sel_ptr;
      end else if (wr_ofs) begin
         ptr_r <= ofs_ptr;
      end else if (rewind) begin
         ptr_r <= rew_ptr;
      end else if ((wr_data || rd_data) && !ptr_oob) begin
         ptr_r <= ptr_r + 14'h0001;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (wr_data && !ptr_oob) begin
         buf_mem[ptr_r[12:0]] <= wdat_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Buffer error flag; a new error wins over the clearing read
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         buf_err_r <= 1'b0;
      end else if (((wr_data || rd_data) && ptr_oob) ||
                   (wr_sel && sel_ptr >= 14'(BUF_DEPTH))) begin
         buf_err_r <= 1'b1;
      end else if (wr_ofs && ofs_ptr >= 14'(BUF_DEPTH)) begin
         buf_err_r <= 1'b1;
      end else if (rd_fire && rd_idx == IDX_CTRL_STATUS) begin
         buf_err_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Start bit and sequencer launch
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         start_r     <= 1'b0;
         seq_start_r <= 1'b0;
      end else begin
         seq_start_r <= 1'b0;
         if (wr_en && aw_idx_r == IDX_CONTROL &&
             wdat_r[CTRL_START_BIT] && !start_r) begin
            // Zero count leaves start clear and launches nothing
            if (txn_count_r != 7'h00) begin
               start_r     <= 1'b1;
               seq_start_r <= 1'b1;
            end
         end else if (SEQ_DONE) begin
            start_r <= 1'b0;
         end
      end
   end

   assign SEQ_START = seq_start_r;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer lookups
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         SEQ_SLAVE_ADDR <= 7'h00;
         SEQ_TXN_LEN    <= 8'h00;
         SEQ_TXN_VALID  <= 1'b0;
         SEQ_TXN_EMPTY  <= 1'b0;
         SEQ_BUF_DATA   <= 8'h00;
      end else begin
         // Direction bit dropped: every transaction is a write
         SEQ_SLAVE_ADDR <= slave_tab[SEQ_TXN_IDX][7:1];
         SEQ_TXN_LEN    <= len_tab[SEQ_TXN_IDX];
         SEQ_TXN_VALID  <= {1'b0, SEQ_TXN_IDX} < txn_count_r;
         SEQ_TXN_EMPTY  <= len_tab[SEQ_TXN_IDX] == 8'h00;
         SEQ_BUF_DATA   <= (SEQ_BUF_ADDR < 13'(BUF_DEPTH)) ?
                           buf_mem[SEQ_BUF_ADDR] : INVALID_DATA;
      end
   end

endmodule

// ==== testbench/seq_model.sv ====
// Behavioural sequencer standing on the far side of the register bank
`timescale 1ns/100ps
module seq_model #(
   parameter int RUN_CYCLES = 20
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic start,
   output logic      busy,
   output logic      done
);
   int cnt;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt  <= 0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= busy && cnt == 1;
         if (start) begin
            busy <= 1'b1;
            cnt  <= RUN_CYCLES;
         end else if (cnt > 0) begin
            cnt  <= cnt - 1;
            busy <= cnt > 1;
         end
      end
   end
endmodule

// ==== testbench/seq_table_bank_sva.sv ====
// Bus handshake and sequencer lookup checks for the register bank
`timescale 1ns/100ps
module seq_table_bank_chk (
   input wire logic        SYS_CLK,
   input wire logic        RESETN,
   input wire logic        S_AXI_AWVALID,
   input wire logic        S_AXI_AWREADY,
   input wire logic        S_AXI_WVALID,
   input wire logic        S_AXI_WREADY,
   input wire logic [1:0]  S_AXI_BRESP,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic        S_AXI_RVALID,
   input wire logic        SEQ_START,
   input wire logic [7:0]  SEQ_TXN_LEN,
   input wire logic        SEQ_TXN_EMPTY,
   input wire logic [12:0] SEQ_BUF_ADDR,
   input wire logic [7:0]  SEQ_BUF_DATA
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);

   AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
      S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("bresp dropped");
   AST_WR_ANSWER: assert property (
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |-> ##[1:2] S_AXI_BVALID) else $error("write not answered");
   AST_RD_ANSWER: assert property (
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read not answered");
   AST_RD_UPPER: assert property (
      S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
      else $error("read upper bits set");
   AST_ONE_READ: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("second read accepted");
   AST_START_PULSE: assert property (SEQ_START |=> !SEQ_START)
      else $error("start longer than one cycle");
   AST_EMPTY_LEN: assert property (
      SEQ_TXN_EMPTY |-> SEQ_TXN_LEN == 8'h00)
      else $error("empty flag with nonzero length");
   AST_BUF_OOR: assert property (
      SEQ_BUF_ADDR >= 13'd4352 |=> SEQ_BUF_DATA == 8'h00)
      else $error("data beyond buffer");
endmodule

bind seq_table_bank seq_table_bank_chk chk_u (
   .SYS_CLK(SYS_CLK), .RESETN(RESETN),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
   .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
   .S_AXI_RVALID(S_AXI_RVALID), .SEQ_START(SEQ_START),
   .SEQ_TXN_LEN(SEQ_TXN_LEN), .SEQ_TXN_EMPTY(SEQ_TXN_EMPTY),
   .SEQ_BUF_ADDR(SEQ_BUF_ADDR), .SEQ_BUF_DATA(SEQ_BUF_DATA)
);

// ==== testbench/test_i2c_sequence_table_buffer_access.sv ====
// Self-checking bench for the sequence table register bank
`timescale 1ns/100ps
module test_i2c_sequence_table_buffer_access;
   import seq_table_pkg::*;
   typedef struct packed {
      logic       w;
      logic [7:0] i;
      logic [7:0] d;
      logic [1:0] r;
   } row_s;
   localparam logic       wr = 1'b1;
   localparam logic       rd = 1'b0;
   localparam logic [1:0] ok = RESP_OKAY;
   localparam logic [1:0] er = RESP_SLVERR;
   localparam logic [7:0] sl = IDX_SLAVE_TABLE;
   localparam logic [7:0] cf = IDX_TXN_CONFIG;
   localparam logic [7:0] dp = IDX_DATA_PORT;
   localparam logic [7:0] ts = IDX_TXN_SELECT;
   localparam logic [7:0] bo = IDX_BYTE_OFFSET;
   localparam logic [7:0] ct = IDX_CONTROL;
   localparam logic [7:0] st = IDX_CTRL_STATUS;
   localparam logic [7:0] un = 8'h01;
   logic        clk, rst_n = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic        bready = 1'b1;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        seq_start, txn_valid, txn_empty, busy, done;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0]  bresp, rresp;
   logic [5:0]  txn_idx = 6'h00;
   logic [6:0]  slv_addr;
   logic [7:0]  txn_len, buf_data;
   logic [12:0] buf_addr = 13'h0000;
   int          mismatches, cmp_count, starts, n;
   row_s        rows [42] = '{
      '{rd,ts,8'h00,ok}, '{rd,bo,8'h00,ok},
      '{wr,cf,8'h03,ok}, '{wr,cf,8'h02,ok}, '{wr,cf,8'h00,ok},
      '{wr,cf,8'h03,ok}, '{wr,sl,8'h21,ok}, '{wr,sl,8'h24,ok},
      '{wr,sl,8'h50,ok}, '{wr,dp,8'h5a,ok}, '{wr,dp,8'ha5,ok},
      '{wr,dp,8'h3c,ok}, '{wr,dp,8'hc3,ok}, '{wr,dp,8'h81,ok},
      '{wr,ct,8'h01,ok}, '{rd,sl,8'h21,ok}, '{rd,sl,8'h24,ok},
      '{rd,dp,8'h5a,ok}, '{rd,dp,8'ha5,ok}, '{rd,dp,8'h3c,ok},
      '{wr,ts,8'h02,ok}, '{rd,dp,8'h3c,ok}, '{wr,bo,8'h01,ok},
      '{rd,dp,8'hc3,ok}, '{rd,dp,8'h81,ok}, '{wr,ct,8'h01,ok},
      '{rd,dp,8'hc3,ok}, '{wr,bo,8'h01,ok}, '{wr,ts,8'h00,ok},
      '{rd,bo,8'h00,ok}, '{rd,dp,8'h5a,ok}, '{wr,ts,8'hc2,ok},
      '{rd,dp,8'h3c,ok}, '{rd,un,8'h00,er}, '{wr,un,8'h00,er},
      '{wr,ct,8'h01,ok}, '{wr,cf,8'h45,ok}, '{wr,ct,8'h01,ok},
      '{rd,cf,8'h40,ok}, '{rd,cf,8'h02,ok}, '{wr,ct,8'h01,ok},
      '{wr,cf,8'h03,ok}
   };

   seq_table_bank dut_u (
      .SYS_CLK(clk), .RESETN(rst_n), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(1'b1), .SEQ_BUSY(busy), .SEQ_DONE(done),
      .SEQ_START(seq_start), .SEQ_TXN_IDX(txn_idx),
      .SEQ_SLAVE_ADDR(slv_addr), .SEQ_TXN_LEN(txn_len),
      .SEQ_TXN_VALID(txn_valid), .SEQ_TXN_EMPTY(txn_empty),
      .SEQ_BUF_ADDR(buf_addr), .SEQ_BUF_DATA(buf_data)
   );
   seq_model seq_u (.clk(clk), .rst_n(rst_n), .start(seq_start),
      .busy(busy), .done(done));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (seq_start === 1'b1) starts++;
   end

   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One register access; d is write data or expected read data
   task automatic bus(input logic w, input logic [7:0] i, d,
                      input logic [1:0] r);
      int k;
      awaddr  <= {2'b00, i, 2'b00};
      araddr  <= {2'b00, i, 2'b00};
      wdata   <= {24'h0, d};
      awvalid <= w;
      wvalid  <= w;
      arvalid <= !w;
      k = 0;
      do begin
         @(posedge clk);
         k++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(w && bvalid) && !(!w && rvalid) && k < 100);
      // A missing answer counts as a mismatch
      if (k >= 100) mismatches++;
      if (w) begin
         chk("bresp", 32'(r), 32'(bresp));
      end else begin
         chk("rresp", 32'(r), 32'(rresp));
         chk("rdata", 32'(d), rdata);
      end
   endtask

   task automatic look(input logic [5:0] i, input logic [12:0] a);
      txn_idx  <= i;
      buf_addr <= a;
      repeat (2) @(posedge clk);
   endtask

   task automatic results;
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      foreach (rows[k]) begin
         bus(rows[k].w, rows[k].i, rows[k].d, rows[k].r);
      end
      look(6'd0, 13'd2);
      chk("slave", 32'h10, 32'(slv_addr));
      chk("len", 32'h02, 32'(txn_len));
      chk("valid", 32'h1, 32'(txn_valid));
      chk("empty", 32'h0, 32'(txn_empty));
      chk("bufdata", 32'h3c, 32'(buf_data));
      look(6'd1, 13'd4352);
      chk("empty", 32'h1, 32'(txn_empty));
      chk("bufdata", 32'h00, 32'(buf_data));
      look(6'd3, 13'd0);
      chk("valid", 32'h0, 32'(txn_valid));
      // Write answer held back by a late response ready
      bready <= 1'b0;
      bus(wr, ts, 8'h00, ok);
      bready <= 1'b1;
      @(posedge clk);
      bus(wr, ct, 8'h02, ok);
      bus(wr, dp, 8'hee, ok);
      bus(rd, st, 8'h02, ok);
      bus(rd, ct, 8'h02, ok);
      n = 0;
      while (busy === 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      if (n >= 200) mismatches++;
      bus(rd, ct, 8'h00, ok);
      bus(wr, ct, 8'h01, ok);
      bus(rd, dp, 8'h5a, ok);
      chk("starts", 32'd1, 32'(starts));
      bus(wr, ct, 8'h01, ok);
      bus(wr, cf, 8'h00, ok);
      bus(wr, ct, 8'h02, ok);
      bus(rd, ct, 8'h00, ok);
      chk("starts", 32'd1, 32'(starts));
      bus(wr, ct, 8'h01, ok);
      bus(wr, cf, 8'h40, ok);
      repeat (18) bus(wr, cf, 8'hff, ok);
      bus(wr, ts, 8'h11, ok);
      bus(wr, bo, 8'h11, ok);
      bus(rd, st, 8'h01, ok);
      bus(rd, st, 8'h00, ok);
      bus(rd, dp, 8'h00, ok);
      bus(rd, st, 8'h01, ok);
      bus(rd, st, 8'h00, ok);
      // Reset in mid-run with select and offset left nonzero
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      bus(rd, ts, 8'h00, ok);
      bus(rd, bo, 8'h00, ok);
      bus(rd, dp, 8'h5a, ok);
      results();
   end

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      results();
   end
endmodule
